/* File: verilog/ascc_pkg.sv */
package ascc_pkg;
	localparam int          ASCC_MAX_PAIRS   = 8;
	localparam int          ASCC_WORD_W      = 24;
	localparam logic [4:0]  ASCC_LAST_BIT    = 5'h17;
	localparam logic [4:0]  ASCC_CMD_LAST    = 5'h07;
	localparam logic [7:0]  ASCC_CMD_SET_WR  = 8'h05;
	localparam logic [7:0]  ASCC_CMD_SET_RD  = 8'h0D;
	localparam logic [7:0]  ASCC_CMD_CFG_WR  = 8'h03;
	localparam logic [7:0]  ASCC_CMD_CFG_RD  = 8'h0B;
	localparam logic [7:0]  ASCC_CMD_NULL    = 8'h00;
	// Configuration word layout; unlisted bits read as zero.
	localparam int          ASCC_CFG_CHOP_LO = 20;
	localparam int          ASCC_CFG_MULTI   = 18;
	localparam int          ASCC_CFG_REPEAT  = 17;
	localparam int          ASCC_CFG_WAIT    = 16;
	localparam int          ASCC_CFG_DP_LO   = 12;
	localparam int          ASCC_CFG_PSS     = 11;
	localparam int          ASCC_CFG_PUMP    = 10;
	localparam int          ASCC_CFG_PSR     = 9;
	localparam int          ASCC_CFG_LPM     = 8;
	localparam logic [23:0] ASCC_CFG_RST     = 24'h00_0000;
	localparam logic [23:0] ASCC_CFG_WMASK   = 24'h37_FF00;
	// Twelve-bit setup layout.
	localparam int          ASCC_SU_LATCH_LO = 10;
	localparam int          ASCC_SU_CHAN_LO  = 7;
	localparam int          ASCC_SU_RATE_LO  = 4;
	localparam int          ASCC_SU_RANGE_LO = 1;
	localparam int          ASCC_SU_POL      = 0;
	localparam logic [11:0] ASCC_SETUP_RST   = 12'h000;
	localparam logic [2:0]  ASCC_RANGE_NU_LO = 3'h6;
	// Oscillator start-up after sleep.
	localparam int          ASCC_CLK_KHZ     = 100_000;
	localparam int          ASCC_WAKE_MS     = 500;
	localparam int          ASCC_WAKE_CYC    = ASCC_WAKE_MS * ASCC_CLK_KHZ;

	typedef enum logic [2:0] {
		PS_CMD    = 3'b000,
		PS_CFG_WR = 3'b001,
		PS_CFG_RD = 3'b010,
		PS_SET_WR = 3'b011,
		PS_SET_RD = 3'b100,
		PS_SKIP   = 3'b101
	} ascc_port_type;

	typedef enum logic [1:0] {
		SQ_IDLE = 2'b00,
		SQ_RUN  = 2'b01,
		SQ_WAIT = 2'b10
	} ascc_seq_type;

	// Conversion period in master clock cycles per word rate code.
	function automatic logic [14:0] ascc_rate_cycles(input logic [2:0] code);
		case (code)
			3'h0: return 15'h0884;
			3'h1: return 15'h0444;
			3'h2: return 15'h0214;
			3'h3: return 15'h0184;
			3'h4: return 15'h0144;
			3'h5: return 15'h4424;
			3'h6: return 15'h2214;
			default: return 15'h110C;
		endcase
	endfunction

	// Calibration codes that start a calibration; code 0 starts a conversion and the rest are reserved.
	function automatic logic ascc_is_cal(input logic [2:0] cc);
		return (cc == 3'h1) || (cc == 3'h2) || (cc == 3'h5) || (cc == 3'h6);
	endfunction
endpackage

/* File: verilog/ascc_arr_if.sv */
`timescale 1ns/1ps
interface ascc_arr_if;
	logic        we;
	logic [2:0]  waddr;
	logic [23:0] wdata;
	logic [2:0]  raddr;
	logic [23:0] rdata;
	logic [3:0]  act_idx;
	logic [11:0] act_setup;
	modport ctrl (output we, waddr, wdata, raddr, act_idx, input rdata, act_setup);
	modport mem  (input we, waddr, wdata, raddr, act_idx, output rdata, act_setup);
endinterface

/* File: verilog/ascc_setup_array.sv */
`timescale 1ns/1ps
module ascc_setup_array
	import ascc_pkg::*;
#(
	parameter int NUM_PAIRS = ASCC_MAX_PAIRS
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic CE,
	ascc_arr_if.mem  arr
);
	logic [23:0] pair_q [ASCC_MAX_PAIRS];

	// One register per pair; pairs beyond the variant's count read as zero.
	for (genvar g = 0; g < ASCC_MAX_PAIRS; g++) begin : g_pair
		logic [23:0] pair_r;
		logic [23:0] pair_nxt;
		always_comb begin
			pair_nxt = pair_r;
			if (g < NUM_PAIRS && arr.we && arr.waddr == 3'(g)) begin
				pair_nxt = arr.wdata;
			end
		end
		always_ff @(posedge CLK or posedge RST) begin
			if (RST) begin
				pair_r <= {ASCC_SETUP_RST, ASCC_SETUP_RST};
			end else if (CE) begin
				pair_r <= pair_nxt;
			end
		end
		assign pair_q[g] = pair_r;
	end

	// Even setup numbers sit in the upper half of their pair.
	assign arr.rdata     = pair_q[arr.raddr];
	assign arr.act_setup = arr.act_idx[0] ? pair_q[arr.act_idx[3:1]][11:0]
		: pair_q[arr.act_idx[3:1]][23:12];
endmodule

/* File: verilog/ascc_top.sv */
`timescale 1ns/1ps
module ascc_top
	import ascc_pkg::*;
#(
	parameter int NUM_PAIRS = ASCC_MAX_PAIRS,
	parameter int WAKE_CYC  = ASCC_WAKE_CYC
) (
	input  wire logic       CLK,
	input  wire logic       RST,
	input  wire logic       CE,
	input  wire logic       CS_N,
	input  wire logic       SCLK,
	input  wire logic       SDI,
	output wire logic       SDO,
	output wire logic       SDO_OE,
	input  wire logic       MASTER_CLOCK_IN,
	input  wire logic       DATA_READ,
	output wire logic [1:0] LATCH_OUT_PINS,
	output wire logic [2:0] INPUT_CHANNEL_SELECT,
	output wire logic [2:0] WORD_RATE_SELECT,
	output wire logic [2:0] INPUT_RANGE_SELECT,
	output wire logic       RANGE_UNUSED,
	output wire logic       UNIPOLAR,
	output wire logic [1:0] CHOP_RATE_SELECT,
	output wire logic       LOW_POWER,
	output wire logic       PUMP_OFF,
	output wire logic       ANALOG_DOWN,
	output wire logic       OSC_STOP,
	output wire logic       WAKING,
	output wire logic       CONVERTING,
	output wire logic       CALIBRATING,
	output wire logic       CONV_DONE,
	output wire logic       DATA_PENDING
);
	ascc_arr_if arr ();

	ascc_setup_array #(.NUM_PAIRS(NUM_PAIRS)) u_array (
		.CLK (CLK),
		.RST (RST),
		.CE  (CE),
		.arr (arr)
	);

	// Pins from the host pass two flops before anything looks at them, except DATA_READ, which is used directly.
	logic cs_s1, cs_s2, sck_s1, sck_s2, sck_d, sdi_s1, sdi_s2, xin_s1, xin_s2, xin_d;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			{cs_s1, cs_s2} <= 2'h3;
			{sck_s1, sck_s2, sck_d} <= 3'h0;
			{sdi_s1, sdi_s2, xin_s1, xin_s2, xin_d} <= 5'h00;
		end else if (CE) begin
			{cs_s1, cs_s2} <= {CS_N, cs_s1};
			{sck_s1, sck_s2, sck_d} <= {SCLK, sck_s1, sck_s2};
			{sdi_s1, sdi_s2} <= {SDI, sdi_s1};
			{xin_s1, xin_s2, xin_d} <= {MASTER_CLOCK_IN, xin_s1, xin_s2};
		end
	end

	logic rise, fall, xin_rise;
	assign rise     = sck_s2 && !sck_d && !cs_s2;
	assign fall     = !sck_s2 && sck_d && !cs_s2;
	assign xin_rise = xin_s2 && !xin_d;

	// Serial port state.
	ascc_port_type port_st_r, port_st_nxt;
	logic [4:0]  bit_cnt_r, bit_cnt_nxt;
	logic [2:0]  pair_cnt_r, pair_cnt_nxt;
	logic [23:0] sh_in_r, sh_in_nxt, sh_out_r, sh_out_nxt, cfg_r, cfg_nxt;
	logic [23:0] word_in;
	logic [2:0]  last_pair;
	logic        arr_we, cmd_evt, set_st, rd_st;

	// Even depth values round up because only bits 3:1 count pairs.
	assign last_pair = (cfg_r[ASCC_CFG_DP_LO+1 +: 3] > 3'(NUM_PAIRS - 1)) ? 3'(NUM_PAIRS - 1)
		: cfg_r[ASCC_CFG_DP_LO+1 +: 3];
	assign word_in   = {sh_in_r[22:0], sdi_s2};
	assign set_st    = (port_st_r == PS_SET_WR) || (port_st_r == PS_SET_RD);
	assign rd_st     = (port_st_r == PS_CFG_RD) || (port_st_r == PS_SET_RD);
	assign cmd_evt   = rise && port_st_r == PS_CMD && bit_cnt_r == ASCC_CMD_LAST;

	assign arr.we    = arr_we;
	assign arr.waddr = pair_cnt_r;
	assign arr.wdata = word_in;
	assign arr.raddr = pair_cnt_r;

	// Bits come in on SCLK rise; read data moves out on SCLK fall.
	always_comb begin
		port_st_nxt  = port_st_r;
		bit_cnt_nxt  = bit_cnt_r;
		pair_cnt_nxt = pair_cnt_r;
		sh_in_nxt    = sh_in_r;
		sh_out_nxt   = sh_out_r;
		cfg_nxt      = cfg_r;
		arr_we       = 1'b0;
		if (cs_s2) begin
			port_st_nxt  = PS_CMD;
			bit_cnt_nxt  = 5'h00;
			pair_cnt_nxt = 3'h0;
		end else if (rise) begin
			sh_in_nxt   = word_in;
			bit_cnt_nxt = bit_cnt_r + 5'h01;
			if (port_st_r == PS_CMD) begin
				if (bit_cnt_r == ASCC_CMD_LAST) begin
					bit_cnt_nxt  = 5'h00;
					pair_cnt_nxt = 3'h0;
					case (word_in[7:0])
						ASCC_CMD_SET_WR: port_st_nxt = PS_SET_WR;
						ASCC_CMD_SET_RD: port_st_nxt = PS_SET_RD;
						ASCC_CMD_CFG_WR: port_st_nxt = PS_CFG_WR;
						ASCC_CMD_CFG_RD: port_st_nxt = PS_CFG_RD;
						default: begin
							// Offset and gain words are swallowed so they are not seen as commands.
							port_st_nxt = (!word_in[7] && word_in[1:0] != 2'h0) ? PS_SKIP : PS_CMD;
						end
					endcase
				end
			end else if (bit_cnt_r == ASCC_LAST_BIT) begin
				bit_cnt_nxt = 5'h00;
				port_st_nxt = PS_CMD;
				if (port_st_r == PS_CFG_WR) begin
					cfg_nxt = word_in & ASCC_CFG_WMASK;
				end
				if (port_st_r == PS_SET_WR) begin
					arr_we = 1'b1;
				end
				if (set_st && pair_cnt_r != last_pair) begin
					port_st_nxt  = port_st_r;
					pair_cnt_nxt = pair_cnt_r + 3'h1;
				end
			end
		end else if (fall && rd_st) begin
			if (bit_cnt_r == 5'h00) begin
				sh_out_nxt = (port_st_r == PS_CFG_RD) ? cfg_r : arr.rdata;
			end else begin
				sh_out_nxt = {sh_out_r[22:0], 1'b0};
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			port_st_r  <= PS_CMD;
			bit_cnt_r  <= 5'h00;
			pair_cnt_r <= 3'h0;
			sh_in_r    <= 24'h00_0000;
			sh_out_r   <= 24'h00_0000;
			cfg_r      <= ASCC_CFG_RST;
		end else if (CE) begin
			port_st_r  <= port_st_nxt;
			bit_cnt_r  <= bit_cnt_nxt;
			pair_cnt_r <= pair_cnt_nxt;
			sh_in_r    <= sh_in_nxt;
			sh_out_r   <= sh_out_nxt;
			cfg_r      <= cfg_nxt;
		end
	end

	assign SDO    = sh_out_r[23];
	assign SDO_OE = !cs_s2 && rd_st;

	// Conversion sequencer state.
	ascc_seq_type seq_st_r, seq_st_nxt;
	logic [3:0]  cur_r, cur_nxt, first_r, first_nxt, last_r, last_nxt, max_setup, dp;
	logic [14:0] per_r, per_nxt;
	logic [25:0] wake_r, wake_nxt;
	logic [11:0] act_r;
	logic        loop_r, loop_nxt, hold_r, hold_nxt, cal_r, cal_nxt;
	logic        done_r, done_nxt, pend_r, pend_nxt, sleep_r, sleep_nxt;
	logic        psr, halt, start, is_cal, multi, done_evt;

	assign dp        = cfg_r[ASCC_CFG_DP_LO +: 4];
	assign max_setup = 4'(2 * NUM_PAIRS - 1);
	assign psr       = cfg_r[ASCC_CFG_PSR];
	assign halt      = psr || wake_r != 26'h000_0000;
	assign is_cal    = ascc_is_cal(word_in[2:0]);
	assign start     = cmd_evt && word_in[7] && (word_in[2:0] == 3'h0 || is_cal);
	assign multi     = cfg_r[ASCC_CFG_MULTI] && !is_cal;
	assign done_evt  = seq_st_r == SQ_RUN && !halt && xin_rise
		&& per_r + 15'h0001 == ascc_rate_cycles(arr.act_setup[ASCC_SU_RATE_LO +: 3]);
	assign arr.act_idx = cur_r;

	// Counting is in master clock cycles, so rates track that clock.
	always_comb begin
		seq_st_nxt = seq_st_r;
		cur_nxt    = cur_r;
		first_nxt  = first_r;
		last_nxt   = last_r;
		loop_nxt   = loop_r;
		hold_nxt   = hold_r;
		cal_nxt    = cal_r;
		per_nxt    = per_r;
		done_nxt   = 1'b0;
		pend_nxt   = (pend_r && !DATA_READ) || done_evt;
		sleep_nxt  = psr && cfg_r[ASCC_CFG_PSS];
		wake_nxt   = (wake_r != 26'h000_0000) ? wake_r - 26'h000_0001 : wake_r;
		if (sleep_r && !psr) begin
			wake_nxt = 26'(WAKE_CYC - 1);
		end
		if (start) begin
			seq_st_nxt = SQ_RUN;
			per_nxt    = 15'h0000;
			first_nxt  = multi ? 4'h0 : word_in[6:3];
			cur_nxt    = multi ? 4'h0 : word_in[6:3];
			last_nxt   = multi ? ((dp > max_setup) ? max_setup : dp) : word_in[6:3];
			loop_nxt   = cfg_r[ASCC_CFG_REPEAT] && !is_cal;
			hold_nxt   = cfg_r[ASCC_CFG_WAIT] && cfg_r[ASCC_CFG_REPEAT] && !is_cal;
			cal_nxt    = is_cal;
		end else if (cmd_evt && seq_st_r != SQ_IDLE && word_in[7:0] != ASCC_CMD_NULL) begin
			seq_st_nxt = SQ_IDLE;
		end else begin
			case (seq_st_r)
				SQ_RUN: begin
					if (!halt && xin_rise) begin
						per_nxt = per_r + 15'h0001;
						if (done_evt) begin
							per_nxt  = 15'h0000;
							done_nxt = 1'b1;
							if (cur_r != last_r) begin
								cur_nxt = cur_r + 4'h1;
							end else if (!loop_r) begin
								seq_st_nxt = SQ_IDLE;
							end else if (hold_r) begin
								seq_st_nxt = SQ_WAIT;
							end else begin
								cur_nxt = first_r;
							end
						end
					end
				end
				SQ_WAIT: begin
					if (!pend_r) begin
						seq_st_nxt = SQ_RUN;
						cur_nxt    = first_r;
					end
				end
				default: begin
					seq_st_nxt = SQ_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			seq_st_r <= SQ_IDLE;
			cur_r    <= 4'h0;
			first_r  <= 4'h0;
			last_r   <= 4'h0;
			loop_r   <= 1'b0;
			hold_r   <= 1'b0;
			cal_r    <= 1'b0;
			per_r    <= 15'h0000;
			done_r   <= 1'b0;
			pend_r   <= 1'b0;
			sleep_r  <= 1'b0;
			wake_r   <= 26'h000_0000;
			act_r    <= ASCC_SETUP_RST;
		end else if (CE) begin
			seq_st_r <= seq_st_nxt;
			cur_r    <= cur_nxt;
			first_r  <= first_nxt;
			last_r   <= last_nxt;
			loop_r   <= loop_nxt;
			hold_r   <= hold_nxt;
			cal_r    <= cal_nxt;
			per_r    <= per_nxt;
			done_r   <= done_nxt;
			pend_r   <= pend_nxt;
			sleep_r  <= sleep_nxt;
			wake_r   <= wake_nxt;
			act_r    <= arr.act_setup;
		end
	end

	// Active setup fields drive the analog side from a register.
	assign LATCH_OUT_PINS       = act_r[ASCC_SU_LATCH_LO +: 2];
	assign INPUT_CHANNEL_SELECT = act_r[ASCC_SU_CHAN_LO +: 3];
	assign WORD_RATE_SELECT     = act_r[ASCC_SU_RATE_LO +: 3];
	assign INPUT_RANGE_SELECT   = act_r[ASCC_SU_RANGE_LO +: 3];
	assign RANGE_UNUSED         = act_r[ASCC_SU_RANGE_LO +: 3] >= ASCC_RANGE_NU_LO;
	assign UNIPOLAR             = act_r[ASCC_SU_POL];
	assign CHOP_RATE_SELECT     = cfg_r[ASCC_CFG_CHOP_LO +: 2];
	assign LOW_POWER            = cfg_r[ASCC_CFG_LPM];
	assign PUMP_OFF             = cfg_r[ASCC_CFG_PUMP];
	assign ANALOG_DOWN          = halt;
	assign OSC_STOP             = sleep_r;
	assign WAKING               = wake_r != 26'h000_0000;
	assign CONVERTING           = seq_st_r != SQ_IDLE;
	assign CALIBRATING          = cal_r && seq_st_r != SQ_IDLE;
	assign CONV_DONE            = done_r;
	assign DATA_PENDING         = pend_r;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	sequence s_set_last;
		CE && rise && set_st && bit_cnt_r == ASCC_LAST_BIT;
	endsequence
	property p_burst_end;
		s_set_last and (pair_cnt_r == last_pair) |=> port_st_r == PS_CMD;
	endproperty
	a_burst_end: assert property (p_burst_end) else $error("burst did not end");
	property p_burst_next;
		s_set_last and (pair_cnt_r != last_pair) |=> set_st && bit_cnt_r == 5'h00
			&& pair_cnt_r == $past(pair_cnt_r) + 3'h1;
	endproperty
	a_burst_next: assert property (p_burst_next) else $error("pair did not advance");
	property p_cfg_wr;
		CE && rise && port_st_r == PS_CFG_WR && bit_cnt_r == ASCC_LAST_BIT
			|=> cfg_r[ASCC_CFG_DP_LO +: 4] == $past(word_in[ASCC_CFG_DP_LO +: 4]);
	endproperty
	a_cfg_wr: assert property (p_cfg_wr) else $error("depth not loaded");
	property p_stop;
		CE && cmd_evt && !word_in[7] && word_in[7:0] != ASCC_CMD_NULL |=> seq_st_r == SQ_IDLE;
	endproperty
	a_stop: assert property (p_stop) else $error("stop ignored");
	property p_pend;
		CE && done_evt |=> DATA_PENDING && CONV_DONE ##1 !CONV_DONE || !CE;
	endproperty
	a_pend: assert property (p_pend) else $error("pending not set");
	property p_wait;
		CE && seq_st_r == SQ_WAIT && pend_r && !DATA_READ && !cmd_evt |=> seq_st_r == SQ_WAIT;
	endproperty
	a_wait: assert property (p_wait) else $error("wait left early");
	property p_multi;
		CE && start && multi |=> cur_r == 4'h0 && first_r == 4'h0;
	endproperty
	a_multi: assert property (p_multi) else $error("multi not from first");
	property p_wake;
		CE && sleep_r && !psr |=> ANALOG_DOWN [*8];
	endproperty
	a_wake: assert property (p_wake) else $error("woke too early");
	property p_halt;
		CE && psr && !start |-> ANALOG_DOWN ##1 per_r == $past(per_r) && !CONV_DONE;
	endproperty
	a_halt: assert property (p_halt) else $error("converting in power save");
endmodule

/* File: bench/ascc_host_model.sv */
`timescale 1ns/1ps
module ascc_host_model (
	input  wire logic CLK,
	output logic      cs_n,
	output logic      sclk,
	output logic      sdi,
	input  wire logic sdo,
	input  wire logic sdo_oe
);
	// Parked deselected with the serial clock low between frames.
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdi  = 1'b0;
	end

	task automatic waitc(input int n);
		repeat (n) @(posedge CLK);
	endtask

	// One frame, MSB first: write data sits left-aligned, read data returns right-aligned.
	task automatic frame(input logic [7:0] cmd, input int nbits, input logic [47:0] wd,
			output logic [47:0] rd);
		logic [55:0] sh;
		int          k;
		sh = {cmd, wd};
		rd = '0;
		@(posedge CLK);
		cs_n <= 1'b0;
		waitc(4);
		for (k = 0; k < 8 + nbits; k++) begin
			sdi <= sh[55-k];
			waitc(4);
			sclk <= 1'b1;
			// A released line is read as the inverse of the previously sampled bit, never as the last driven bit.
			if (k >= 8) rd = {rd[46:0], sdo_oe ? sdo : ~rd[0]};
			waitc(4);
			sclk <= 1'b0;
		end
		waitc(4);
		cs_n <= 1'b1;
		sdi  <= ~sdi;
		waitc(4);
	endtask
endmodule

/* File: bench/test_adc_setup_and_config_control.sv */
`timescale 1ns/1ps
module test_adc_setup_and_config_control
	import ascc_pkg::*;
;
	logic        clk, rst, ce, mclk, data_read;
	logic        cs_n, sclk, sdi, sdo, sdo_oe;
	logic [1:0]  latch, chop;
	logic [2:0]  chan, rate, range_sel;
	logic        range_nu, unipolar, low_power, pump_off, analog_down;
	logic        osc_stop, waking, converting, calibrating, conv_done, pending;
	logic [47:0] rd;
	logic [11:0] rows [8] = '{12'hFFF, 12'h000, 12'h49C, 12'h925,
	                          12'h34A, 12'hEB9, 12'h256, 12'h5E3};
	logic [2:0]  chs [4]  = '{3'h5, 3'h2, 3'h7, 3'h0};
	int          n_errors, checked, ndone, n, i;

	ascc_top #(.NUM_PAIRS(8), .WAKE_CYC(200)) dut_u (
		.CLK(clk), .RST(rst), .CE(ce), .CS_N(cs_n), .SCLK(sclk), .SDI(sdi), .SDO(sdo),
		.SDO_OE(sdo_oe), .MASTER_CLOCK_IN(mclk), .DATA_READ(data_read),
		.LATCH_OUT_PINS(latch), .INPUT_CHANNEL_SELECT(chan), .WORD_RATE_SELECT(rate),
		.INPUT_RANGE_SELECT(range_sel), .RANGE_UNUSED(range_nu), .UNIPOLAR(unipolar),
		.CHOP_RATE_SELECT(chop), .LOW_POWER(low_power), .PUMP_OFF(pump_off),
		.ANALOG_DOWN(analog_down), .OSC_STOP(osc_stop), .WAKING(waking),
		.CONVERTING(converting), .CALIBRATING(calibrating), .CONV_DONE(conv_done),
		.DATA_PENDING(pending)
	);

	ascc_host_model host_u (
		.CLK(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe)
	);

	// Free-running 100 MHz system clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Master clock at a quarter of the system clock, so one period is four cycles.
	always @(posedge clk) begin
		if ($time % 20 == 5) mclk <= ~mclk;
		if (conv_done === 1'b1) ndone <= ndone + 1;
	end

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input logic [47:0] g, input logic [47:0] e);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic wcfg(input logic [23:0] v);
		host_u.frame(ASCC_CMD_CFG_WR, 24, {v, 24'h00_0000}, rd);
	endtask

	task automatic cmd(input logic [7:0] c);
		host_u.frame(c, 0, 48'h0000_0000_0000, rd);
	endtask

	// Waits for the next completion pulse and reports how many cycles that took.
	task automatic wdone();
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (conv_done !== 1'b1 && n < 3000);
		if (n >= 3000) chk(48'(n), 48'h0000_0000_0000);
	endtask

	// Hangs are cut short well beyond the expected run length.
	initial begin
		#1ms;
		n_errors++;
		close_out();
	end

	initial begin
		rst = 1'b1; ce = 1'b1; mclk = 1'b0; data_read = 1'b0;
		n_errors = 0; checked = 0; ndone = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		host_u.waitc(4);
		chk({latch, chan, rate, range_sel, unipolar, chop, low_power, analog_down, osc_stop},
			48'h0000_0000_0000);
		host_u.frame(ASCC_CMD_CFG_RD, 24, 48'h0000_0000_0000, rd);
		chk(rd, 48'h0000_0000_0000);
		$display("test reset done");

		// Table: each setup lands on the pins once a conversion uses it.
		wcfg(24'h00_1000);
		for (i = 0; i < 8; i++) begin
			host_u.frame(ASCC_CMD_SET_WR, 24, {rows[i], 36'h0_0000_0000}, rd);
			cmd(8'h80);
			host_u.waitc(10);
			chk({latch, chan, rate, range_sel, unipolar}, rows[i]);
			chk(range_nu, rows[i][3:1] >= ASCC_RANGE_NU_LO);
		end
		cmd(ASCC_CMD_CFG_RD);
		$display("test setup table done");

		for (i = 0; i < 4; i++) begin
			wcfg({2'b11, 2'(i), 20'h0_3100});
			chk({chop, low_power}, {2'(i), 1'b1});
		end
		host_u.frame(ASCC_CMD_CFG_RD, 24, 48'h0000_0000_0000, rd);
		chk(rd, 48'h0000_0030_3100);
		$display("test config done");

		wcfg(24'h00_3000);
		host_u.frame(ASCC_CMD_SET_WR, 48, 48'hA12_345_B67_8C9, rd);
		host_u.frame(ASCC_CMD_SET_RD, 48, 48'h0000_0000_0000, rd);
		chk(rd, 48'hA12_345_B67_8C9);
		host_u.frame(ASCC_CMD_CFG_RD, 24, 48'h0000_0000_0000, rd);
		chk(rd, 48'h0000_0000_3000);
		wcfg(24'h00_2000);
		host_u.frame(ASCC_CMD_SET_RD, 48, 48'h0000_0000_0000, rd);
		chk(rd, 48'hA12_345_B67_8C9);
		$display("test burst done");

		// Multi-setup run without loop: the wait bit must not hold it.
		wcfg(24'h05_3000);
		host_u.frame(ASCC_CMD_SET_WR, 48, {2'b00, chs[0], 7'h40, 2'b00, chs[1], 7'h40,
			2'b00, chs[2], 7'h40, 2'b00, chs[3], 7'h40}, rd);
		cmd(8'h80);
		chk(chan, chs[0]);
		for (i = 0; i < 4; i++) begin
			wdone();
			if (i > 0) chk(48'(n), 48'((n > 1289 && n < 1303) ? n : 1296));
			host_u.waitc(3);
			if (i < 3) chk(chan, chs[i+1]);
		end
		host_u.waitc(1400);
		chk({converting, ndone[2:0]}, 4'h4);
		$display("test multi done");

		// Loop with wait-for-read holds until the data is taken, then a stop ends it.
		wcfg(24'h03_1000);
		cmd(8'h80);
		wdone();
		host_u.waitc(2);
		n = ndone;
		chk(pending, 1'b1);
		host_u.waitc(1500);
		chk({converting, 32'(ndone)}, {1'b1, 32'(n)});
		data_read <= 1'b1;
		@(posedge clk);
		data_read <= 1'b0;
		wdone();
		chk(48'(n < 1310), 48'h0000_0000_0001);
		cmd(ASCC_CMD_CFG_RD);
		host_u.waitc(10);
		chk(converting, 1'b0);
		$display("test loop done");

		wcfg(24'h00_0A00);
		host_u.waitc(3);
		chk({analog_down, osc_stop}, 2'b11);
		wcfg(24'h00_0000);
		chk({waking, analog_down}, 2'b11);
		n = 0;
		while (waking === 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		host_u.waitc(2);
		chk({analog_down, osc_stop, 1'(n > 180 && n < 200)}, 3'b001);
		wcfg(24'h00_0200);
		host_u.waitc(3);
		chk({analog_down, osc_stop}, 2'b10);
		wcfg(24'h00_0000);
		host_u.waitc(3);
		chk({analog_down, waking}, 2'b00);
		$display("test power done");

		// Clock enable low freezes everything, even a whole configuration frame.
		wcfg(24'h30_0400);
		chk({chop, pump_off}, 3'b111);
		ce <= 1'b0;
		wcfg(24'h00_0100);
		ce <= 1'b1;
		host_u.frame(ASCC_CMD_CFG_RD, 24, 48'h0000_0000_0000, rd);
		chk(rd, 48'h0000_0030_0400);
		cmd(8'h81);
		chk({calibrating, converting}, 2'b11);
		cmd(ASCC_CMD_CFG_RD);
		chk(calibrating, 1'b0);
		$display("test enable done");

		// A second reset in mid-run clears configuration, sequencer and setups alike.
		cmd(8'h80);
		rst <= 1'b1;
		host_u.waitc(3);
		rst <= 1'b0;
		host_u.waitc(4);
		chk({chop, pump_off, converting, latch, chan, rate},
			48'h0000_0000_0000);
		host_u.frame(ASCC_CMD_SET_RD, 24, 48'h0000_0000_0000, rd);
		chk(rd, 48'h0000_0000_0000);
		$display("test second reset done");
		close_out();
	end
endmodule
